// *** design/lcd_regs.svh ***
// Opcodes, status bit positions, reset values and timing counts of the LCD command decoder.
`ifndef LCD_REGS_SVH
`define LCD_REGS_SVH
`define LCD_OP_DISP      7'h57
`define LCD_OP_SEGDIR    7'h50
`define LCD_OP_BIAS      7'h51
`define LCD_OP_ALLON     7'h52
`define LCD_OP_INV       7'h53
`define LCD_OP_PSMODE    7'h56
`define LCD_OP_EV        8'h81
`define LCD_OP_RMW       8'hE0
`define LCD_OP_RESET     8'hE2
`define LCD_OP_NOP       8'hE3
`define LCD_OP_END       8'hEE
`define LCD_OP_BOOST     8'hF8
`define LCD_PFX_LINE     2'h1
`define LCD_PFX_COLL     4'h0
`define LCD_PFX_COLH     4'h1
`define LCD_PFX_PAGE     4'hB
`define LCD_PFX_COMDIR   4'hC
`define LCD_PFX_TEST     4'hF
`define LCD_PFX_RATIO    5'h04
`define LCD_PFX_PWR      5'h05
`define LCD_ST_BUSY      7
`define LCD_ST_SEGREV    6
`define LCD_ST_DISP      5
`define LCD_ST_RST       4
`define LCD_RST_RATIO    3'h4
`define LCD_RST_EV       6'h20
`define LCD_RST_WAKE     1'h1
`define LCD_PIN_IDLE     8'h97
`define LCD_COL_LAST     8'h83
`define LCD_PAGE_ICON    4'h8
`define LCD_COLS         132
`define LCD_PAGES        9
`define LCD_CLK_MHZ      25
`define LCD_RST_TIME_NS  1000
`define LCD_RST_CYC      ((`LCD_RST_TIME_NS * `LCD_CLK_MHZ + 999) / 1000)
`endif

// *** design/lcd_pkg.sv ***
// Shared types of the LCD command decoder.
package lcd_pkg;
    typedef enum logic [4:0] {
        LCD_C_NONE, LCD_C_DISP, LCD_C_LINE, LCD_C_PAGE, LCD_C_COLH, LCD_C_COLL,
        LCD_C_SEGDIR, LCD_C_INV, LCD_C_ALLON, LCD_C_BIAS, LCD_C_RMW, LCD_C_END,
        LCD_C_RESET, LCD_C_NOP, LCD_C_COMDIR, LCD_C_PWR, LCD_C_RATIO, LCD_C_EV,
        LCD_C_PSMODE, LCD_C_BOOST, LCD_C_TEST
    } lcd_cmd_t;

    // Parameter byte expected next; Gray coded.
    typedef enum logic [1:0] {
        LCD_P_NONE  = 2'b00,
        LCD_P_EV    = 2'b01,
        LCD_P_BOOST = 2'b11,
        LCD_P_PSAVE = 2'b10
    } lcd_pend_t;

    typedef struct packed {
        logic       display_on;
        logic       reverse_video;
        logic       all_pixels_on;
        logic       seg_scan_reverse;
        logic       com_scan_reverse;
        logic       bias_sel;
        logic       boost_on;
        logic       regulator_on;
        logic       follower_on;
        logic [2:0] divider_ratio_code;
        logic [5:0] contrast_code;
        logic [1:0] pump_multiplier;
        logic       wake_mode;
        logic       rmw_mode;
        logic       test_mode;
        logic       static_icon_on;
        logic [1:0] static_icon_code;
        logic [5:0] start_line;
    } lcd_cfg_t;

    typedef struct packed {
        logic power_save;
        logic osc_run;
        logic outputs_ground;
        logic boost_en;
        logic regulator_en;
        logic follower_en;
    } lcd_drive_t;

    typedef struct packed {
        logic [3:0] page;
        logic [7:0] column;
    } lcd_addr_t;
endpackage

// *** design/lcd_disp_ram.sv ***
// Display data memory with registered read data.
`timescale 1ns/10ps
module lcd_disp_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 1188,
    parameter int AW    = 11
) (
    input  wire logic             clk,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    addr,
    input  wire logic [WIDTH-1:0] wdata,
    output logic      [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Read data is always registered so the host sees a flop, never the array.
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

// *** design/lcd_cmd_decoder.sv ***
// Command and data decoder of the dot-matrix LCD controller.
`timescale 1ns/10ps
`include "lcd_regs.svh"
module lcd_cmd_decoder #(
    parameter int RST_CYC = `LCD_RST_CYC
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              hw_init_n,
    input  wire logic              bus_cs_n,
    input  wire logic              bus_wr_n,
    input  wire logic              bus_rd_n,
    input  wire logic              cmd_or_data,
    input  wire logic [7:0]        data_in,
    output logic      [7:0]        data_out,
    output logic                   data_oe,
    input  wire logic              ser_cs_n,
    input  wire logic              ser_clk,
    input  wire logic              ser_din,
    output lcd_pkg::lcd_cfg_t      cfg,
    output lcd_pkg::lcd_drive_t    drive,
    output lcd_pkg::lcd_addr_t     addr,
    output logic                   busy,
    output logic                   reset_active
);
    import lcd_pkg::*;

    localparam int P_WR  = 0;
    localparam int P_RD  = 1;
    localparam int P_CS  = 2;
    localparam int P_COD = 3;
    localparam int P_SCS = 4;
    localparam int P_SCK = 5;
    localparam int P_SDI = 6;
    localparam int P_RES = 7;
    localparam int CW    = $clog2(RST_CYC + 1);

    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] filt;
        logic [7:0] d1;
        logic [7:0] d2;
        logic [7:0] d3;
        lcd_cfg_t   cfg;
        lcd_drive_t drive;
        lcd_addr_t  ptr;
        logic [7:0] rmw_col;
        lcd_pend_t  pend;
        logic       psave_md;
        logic [2:0] ser_cnt;
        logic [6:0] ser_sr;
        logic [CW-1:0] rst_cnt;
        logic       hw_hold;
        logic       exec;
        logic       rd_fetch;
        logic [7:0] dout;
    } lcd_state_t;

    lcd_state_t q;
    lcd_state_t n;

    logic [7:0]  pins;
    logic [7:0]  filt_n;
    logic [7:0]  rise;
    logic [7:0]  fall;
    logic        wr_done;
    logic        rd_start;
    logic        rd_end;
    logic        ser_done;
    logic        is_data;
    logic        busy_now;
    logic        accept;
    logic [7:0]  byte_val;
    lcd_cmd_t    cmd;
    logic        ptr_ok;
    logic [10:0] ram_addr;
    logic        ram_we;
    logic [7:0]  ram_wdata;
    logic [7:0]  ram_rdata;

    // Classifies a command byte; specific opcodes are matched ahead of prefixes, except the test prefix, which only the booster opcode precedes.
    function automatic lcd_cmd_t lcd_decode(input logic [7:0] b);
        lcd_cmd_t c;
        c = LCD_C_NONE;
        if (b == `LCD_OP_BOOST)                c = LCD_C_BOOST;
        else if (b[7:4] == `LCD_PFX_TEST)      c = LCD_C_TEST;
        else if (b == `LCD_OP_RMW)             c = LCD_C_RMW;
        else if (b == `LCD_OP_END)             c = LCD_C_END;
        else if (b == `LCD_OP_RESET)           c = LCD_C_RESET;
        else if (b == `LCD_OP_NOP)             c = LCD_C_NOP;
        else if (b == `LCD_OP_EV)              c = LCD_C_EV;
        else if (b[7:1] == `LCD_OP_DISP)       c = LCD_C_DISP;
        else if (b[7:1] == `LCD_OP_SEGDIR)     c = LCD_C_SEGDIR;
        else if (b[7:1] == `LCD_OP_BIAS)       c = LCD_C_BIAS;
        else if (b[7:1] == `LCD_OP_ALLON)      c = LCD_C_ALLON;
        else if (b[7:1] == `LCD_OP_INV)        c = LCD_C_INV;
        else if (b[7:1] == `LCD_OP_PSMODE)     c = LCD_C_PSMODE;
        else if (b[7:6] == `LCD_PFX_LINE)      c = LCD_C_LINE;
        else if (b[7:4] == `LCD_PFX_PAGE)      c = LCD_C_PAGE;
        else if (b[7:4] == `LCD_PFX_COMDIR)    c = LCD_C_COMDIR;
        else if (b[7:4] == `LCD_PFX_COLH)      c = LCD_C_COLH;
        else if (b[7:4] == `LCD_PFX_COLL)      c = LCD_C_COLL;
        else if (b[7:3] == `LCD_PFX_PWR)       c = LCD_C_PWR;
        else if (b[7:3] == `LCD_PFX_RATIO)     c = LCD_C_RATIO;
        return c;
    endfunction

    // Defaults shared by the hardware and the software reset.
    function automatic lcd_cfg_t lcd_sw_defaults(input lcd_cfg_t c);
        lcd_cfg_t r;
        r = c;
        r.rmw_mode           = 1'b0;
        r.test_mode          = 1'b0;
        r.static_icon_on     = 1'b0;
        r.static_icon_code   = 2'h0;
        r.start_line         = 6'h00;
        r.com_scan_reverse   = 1'b0;
        r.divider_ratio_code = `LCD_RST_RATIO;
        r.contrast_code      = `LCD_RST_EV;
        return r;
    endfunction

    // Pin sampling: a change counts once the second and third stages agree.
    assign pins     = {hw_init_n, ser_din, ser_clk, ser_cs_n, cmd_or_data,
                       bus_cs_n, bus_rd_n, bus_wr_n};
    assign filt_n   = (q.s2 & q.s3) | (q.filt & (q.s2 ^ q.s3));
    assign rise     = ~q.filt & filt_n;
    assign fall     = q.filt & ~filt_n;
    assign wr_done  = rise[P_WR] & ~q.filt[P_CS];
    assign rd_start = fall[P_RD] & ~filt_n[P_CS];  // Select may fall with the strobe.
    assign rd_end   = rise[P_RD] & ~q.filt[P_CS];
    assign ser_done = ~q.filt[P_SCS] & rise[P_SCK] & (q.ser_cnt == 3'h7);
    assign is_data  = filt_n[P_COD];

    // Busy covers the hardware hold, the reset procedure and one execute cycle.
    assign busy_now = q.hw_hold | (q.rst_cnt != '0) | q.exec;
    assign accept   = (wr_done | ser_done) & ~busy_now;
    assign byte_val = ser_done ? {q.ser_sr, filt_n[P_SDI]} : q.d3;
    assign cmd      = lcd_decode(byte_val);

    // Pointers beyond page 8 or column 131 are never stored into RAM.
    assign ptr_ok    = (q.ptr.page <= `LCD_PAGE_ICON) && (q.ptr.column <= `LCD_COL_LAST);
    assign ram_addr  = 11'(int'(q.ptr.page) * `LCD_COLS + int'(q.ptr.column));
    assign ram_we    = accept & is_data & ptr_ok;
    assign ram_wdata = (q.ptr.page == `LCD_PAGE_ICON) ? {7'h00, byte_val[0]} : byte_val;

    lcd_disp_ram #(
        .WIDTH (8),
        .DEPTH (`LCD_COLS * `LCD_PAGES),
        .AW    (11)
    ) u_ram (
        .clk   (clk),
        .wr_en (ram_we),
        .addr  (ram_addr),
        .wdata (ram_wdata),
        .rdata (ram_rdata)
    );

    // Next-state logic for the whole decoder.
    always_comb
    begin
        n      = q;
        n.s1   = pins;
        n.s2   = q.s1;
        n.s3   = q.s2;
        n.filt = filt_n;
        n.d1   = data_in;
        n.d2   = q.d1;
        n.d3   = q.d2;
        n.exec = accept;
        if (q.rst_cnt != '0)
        begin
            n.rst_cnt = q.rst_cnt - CW'(1);
        end
        // Serial link: MSB first, counter held clear while deselected.
        if (q.filt[P_SCS])
        begin
            n.ser_cnt = 3'h0;
        end
        else if (rise[P_SCK])
        begin
            n.ser_sr  = {q.ser_sr[5:0], filt_n[P_SDI]};
            n.ser_cnt = q.ser_cnt + 3'h1;
        end
        // Reads: status is latched at once, RAM data one cycle later.
        n.rd_fetch = 1'b0;
        if (rd_start && !is_data)
        begin
            n.dout = {busy_now, q.cfg.seg_scan_reverse, q.cfg.display_on,
                      q.hw_hold | (q.rst_cnt != '0), 4'h0};
        end
        else if (rd_start && !busy_now)
        begin
            n.rd_fetch = 1'b1;
        end
        if (q.rd_fetch)
        begin
            n.dout = ram_rdata;
        end
        // Column advances after a read unless read-modify-write holds it.
        if (rd_end && is_data && !busy_now && !q.cfg.rmw_mode &&
            q.ptr.column < `LCD_COL_LAST)
        begin
            n.ptr.column = q.ptr.column + 8'h01;
        end
        if (accept && is_data && q.ptr.column < `LCD_COL_LAST)
        begin
            n.ptr.column = q.ptr.column + 8'h01;
        end
        else if (accept && !is_data && q.pend != LCD_P_NONE)
        begin
            // The byte after a prefix is consumed as a parameter only.
            unique case (q.pend)
                LCD_P_EV:    n.cfg.contrast_code   = byte_val[5:0];
                LCD_P_BOOST: n.cfg.pump_multiplier = byte_val[1:0];
                LCD_P_PSAVE: n.cfg.wake_mode       = q.psave_md;
                LCD_P_NONE:  n.pend                = LCD_P_NONE;
            endcase
            n.pend = LCD_P_NONE;
        end
        else if (accept && !is_data)
        begin
            unique case (cmd)
                LCD_C_DISP:   n.cfg.display_on       = byte_val[0];
                LCD_C_LINE:   n.cfg.start_line       = byte_val[5:0];
                LCD_C_PAGE:   n.ptr.page             = byte_val[3:0];
                LCD_C_COLH:   n.ptr.column[7:4]      = byte_val[3:0];
                LCD_C_COLL:   n.ptr.column[3:0]      = byte_val[3:0];
                LCD_C_SEGDIR: n.cfg.seg_scan_reverse = byte_val[0];
                LCD_C_INV:    n.cfg.reverse_video    = byte_val[0];
                LCD_C_ALLON:  n.cfg.all_pixels_on    = byte_val[0];
                LCD_C_BIAS:   n.cfg.bias_sel         = byte_val[0];
                LCD_C_COMDIR: n.cfg.com_scan_reverse = byte_val[3];
                LCD_C_RATIO:  n.cfg.divider_ratio_code = byte_val[2:0];
                LCD_C_PWR:
                begin
                    n.cfg.boost_on     = byte_val[2];
                    n.cfg.regulator_on = byte_val[1];
                    n.cfg.follower_on  = byte_val[0];
                end
                LCD_C_RMW:
                begin
                    n.cfg.rmw_mode = 1'b1;
                    n.rmw_col      = q.ptr.column;
                end
                LCD_C_END:
                begin
                    if (q.cfg.rmw_mode)
                    begin
                        n.ptr.column = q.rmw_col;
                    end
                    n.cfg.rmw_mode = 1'b0;
                end
                LCD_C_RESET:
                begin
                    n.cfg     = lcd_sw_defaults(q.cfg);
                    n.ptr     = '0;
                    n.rst_cnt = CW'(RST_CYC);
                end
                LCD_C_NOP:    n.cfg.test_mode = 1'b0;
                LCD_C_TEST:   n.cfg.test_mode = 1'b1;
                LCD_C_EV:     n.pend = LCD_P_EV;
                LCD_C_BOOST:  n.pend = LCD_P_BOOST;
                LCD_C_PSMODE:
                begin
                    n.pend     = LCD_P_PSAVE;
                    n.psave_md = byte_val[0];
                end
                LCD_C_NONE:   n.pend = LCD_P_NONE;
            endcase
        end
        // Hardware reset holds while the pin stays low, then runs the reset timer.
        n.hw_hold = ~filt_n[P_RES];
        if (!filt_n[P_RES])
        begin
            n.cfg                  = lcd_sw_defaults(q.cfg);
            n.cfg.display_on       = 1'b0;
            n.cfg.reverse_video    = 1'b0;
            n.cfg.all_pixels_on    = 1'b0;
            n.cfg.seg_scan_reverse = 1'b0;
            n.cfg.bias_sel         = 1'b0;
            n.cfg.pump_multiplier  = 2'h0;
            n.cfg.boost_on         = 1'b0;
            n.cfg.regulator_on     = 1'b0;
            n.cfg.follower_on      = 1'b0;
            n.ptr                  = '0;
            n.ser_cnt              = 3'h0;
            n.ser_sr               = 7'h00;
            n.pend                 = LCD_P_NONE;
            n.rst_cnt              = CW'(RST_CYC);
        end
        // Power save is display off with all pixels on; settings stay untouched.
        n.drive.power_save     = ~n.cfg.display_on & n.cfg.all_pixels_on;
        n.drive.osc_run        = ~n.drive.power_save;
        n.drive.outputs_ground = ~n.cfg.display_on;
        n.drive.boost_en       = n.cfg.boost_on & ~n.drive.power_save;
        n.drive.regulator_en   = n.cfg.regulator_on & ~n.drive.power_save;
        n.drive.follower_en    = n.cfg.follower_on & ~n.drive.power_save;
    end

    // State register; reset brings the chip to its hardware-reset condition.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            q                   <= '0;
            q.s1                <= `LCD_PIN_IDLE;
            q.s2                <= `LCD_PIN_IDLE;
            q.s3                <= `LCD_PIN_IDLE;
            q.filt              <= `LCD_PIN_IDLE;
            q.cfg               <= lcd_sw_defaults('0);
            q.cfg.wake_mode     <= `LCD_RST_WAKE;
            q.drive.outputs_ground <= 1'b1;
            q.drive.osc_run     <= 1'b1;
            q.rst_cnt           <= CW'(RST_CYC);
        end
        else
        begin
            q <= n;
        end
    end

    assign data_out     = q.dout;
    assign data_oe      = ~q.filt[P_CS] & ~q.filt[P_RD];
    assign cfg          = q.cfg;
    assign drive        = q.drive;
    assign addr         = q.ptr;
    assign busy         = busy_now;
    assign reset_active = q.hw_hold | (q.rst_cnt != '0);

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence cmd_taken(lcd_cmd_t c);
        accept && !is_data && q.pend == LCD_P_NONE && cmd == c;
    endsequence

    hw_reset_defaults_a: assert property (!filt_n[P_RES] |=> !cfg.display_on && !cfg.boost_on
        && cfg.pump_multiplier == 2'h0 && !cfg.seg_scan_reverse && !cfg.bias_sel)
        else $error("hardware reset defaults wrong");
    sw_reset_values_a: assert property (cmd_taken(LCD_C_RESET) |=> addr == '0
        && cfg.contrast_code == `LCD_RST_EV && cfg.display_on == $past(cfg.display_on))
        else $error("software reset values wrong");
    display_ground_a: assert property (cmd_taken(LCD_C_DISP) |=>
        cfg.display_on == $past(byte_val[0]) && drive.outputs_ground == !cfg.display_on)
        else $error("display flag or grounding wrong");
    column_advance_a: assert property (accept && is_data && q.ptr.column < `LCD_COL_LAST
        |=> addr.column == $past(q.ptr.column) + 8'h01 && $stable(addr.page))
        else $error("column did not advance");
    column_stop_a: assert property (accept && is_data && q.ptr.column == `LCD_COL_LAST
        |=> addr.column == `LCD_COL_LAST)
        else $error("column passed last");
    rmw_read_hold_a: assert property (rd_end && is_data && q.cfg.rmw_mode && !accept
        |=> $stable(addr.column))
        else $error("column moved on rmw read");
    rmw_restore_a: assert property (cmd_taken(LCD_C_END) && q.cfg.rmw_mode
        |=> addr.column == $past(q.rmw_col) && !cfg.rmw_mode)
        else $error("column not restored");
    param_only_a: assert property (accept && !is_data && q.pend == LCD_P_EV
        |=> cfg.contrast_code == $past(byte_val[5:0]) && $stable(cfg.display_on)
        && q.pend == LCD_P_NONE)
        else $error("parameter byte decoded as command");
    status_byte_a: assert property (rd_start && !is_data
        |=> data_out[3:0] == 4'h0 && data_out[`LCD_ST_SEGREV] == $past(cfg.seg_scan_reverse)
        && data_out[`LCD_ST_BUSY] == $past(busy_now))
        else $error("status byte wrong");
    reset_busy_a: assert property (cmd_taken(LCD_C_RESET) |=> busy [*8])
        else $error("busy dropped during reset");
    power_save_a: assert property (drive.power_save |-> !drive.osc_run
        && !drive.boost_en && drive.outputs_ground)
        else $error("power save left circuits running");
endmodule

// *** tb/lcd_host_model.sv ***
// Host processor model driving the parallel bus of the LCD command decoder.
`timescale 1ns/10ps
module lcd_host_model (
    input  wire logic       clk,
    input  wire logic       busy,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    output logic            cs_n,
    output logic            wr_n,
    output logic            rd_n,
    output logic            a0,
    output logic [7:0]      dbus,
    output logic            scs_n,
    output logic            sck,
    output logic            sdi,
    output logic            hang
);
    // Strobes idle high; the data lines always carry a defined value.
    initial
    begin
        cs_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        a0 = 1'b0;
        dbus = 8'h00;
        scs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
        hang = 1'b0;
    end

    // Bytes sent while busy would be dropped, so wait, but never forever.
    task automatic idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 200)
            hang <= 1'b1;
    endtask

    // Byte write; the filter needs at least two clocks on each side of the strobe.
    task automatic w(input logic dat, input logic [7:0] b);
        idle();
        @(posedge clk);
        cs_n <= 1'b0;
        a0 <= dat;
        dbus <= b;
        wr_n <= 1'b0;
        repeat (5) @(posedge clk);
        wr_n <= 1'b1;
        repeat (6) @(posedge clk);
        cs_n <= 1'b1;
        dbus <= ~b;
    endtask

    // Byte read; our own drivers show a changed value while the device owns the bus.
    task automatic r(input logic dat, output logic [7:0] v);
        idle();
        @(posedge clk);
        cs_n <= 1'b0;
        a0 <= dat;
        rd_n <= 1'b0;
        dbus <= ~dbus;
        repeat (8) @(posedge clk);
        v = data_oe ? data_out : ~data_out;
        rd_n <= 1'b1;
        repeat (6) @(posedge clk);
        cs_n <= 1'b1;
    endtask

    // Serial command byte, MSB first; the clock stands low outside the frame.
    task automatic s(input logic [7:0] b);
        int i;
        idle();
        @(posedge clk);
        scs_n <= 1'b0;
        a0 <= 1'b0;
        for (i = 7; i >= 0; i--)
        begin
            sdi <= b[i];
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            repeat (4) @(posedge clk);
            sck <= 1'b0;
        end
        repeat (4) @(posedge clk);
        scs_n <= 1'b1;
    endtask
endmodule

// *** tb/tb.sv ***
// Self-checking testbench of the LCD command decoder.
`timescale 1ns/10ps
module tb;
    import lcd_pkg::*;
    logic       clk = 1'b0;
    logic       srst;
    logic       hw_init_n;
    logic       cs_n, wr_n, rd_n, a0, busy, hang, oe, rst_act, scs_n, sck, sdi;
    logic [7:0] dbus, dout, v;
    lcd_cfg_t   cfg;
    lcd_drive_t drive;
    lcd_addr_t  addr;
    int         mismatches = 0;
    int         cmp_count = 0;

    lcd_cmd_decoder #(.RST_CYC(8)) i_lcd_cmd_decoder (
        .clk(clk), .srst(srst), .hw_init_n(hw_init_n), .bus_cs_n(cs_n), .bus_wr_n(wr_n),
        .bus_rd_n(rd_n), .cmd_or_data(a0), .data_in(dbus), .data_out(dout), .data_oe(oe),
        .ser_cs_n(scs_n), .ser_clk(sck), .ser_din(sdi), .cfg(cfg), .drive(drive),
        .addr(addr), .busy(busy), .reset_active(rst_act)
    );
    lcd_host_model h (
        .clk(clk), .busy(busy), .data_out(dout), .data_oe(oe), .cs_n(cs_n), .wr_n(wr_n),
        .rd_n(rd_n), .a0(a0), .dbus(dbus), .scs_n(scs_n), .sck(sck), .sdi(sdi), .hang(hang)
    );

    // Free-running 25 MHz clock.
    initial
    begin
        forever #20 clk = ~clk;
    end

    // One comparison; a mismatch is printed and counted at once.
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // A stuck busy flag ends the run here instead of hanging it.
    always @(posedge hang)
    begin
        mismatches++;
        report_and_stop();
    end

    // Main sequence of command and data transfers.
    initial
    begin
        srst <= 1'b1;
        hw_init_n <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        h.r(1'b0, v);
        chk("status", 8'h00, v);
        chk("contrast", 8'h20, 8'(cfg.contrast_code));
        chk("ratio", 8'h04, 8'(cfg.divider_ratio_code));
        chk("wake", 8'h01, 8'(cfg.wake_mode));
        h.w(1'b0, 8'hAF);
        h.w(1'b0, 8'hA1);
        h.r(1'b0, v);
        chk("status", 8'h60, v);
        h.w(1'b0, 8'h2F);
        chk("supply", 8'h07, 8'({cfg.boost_on, cfg.regulator_on, cfg.follower_on}));
        h.w(1'b0, 8'h23);
        chk("ratio", 8'h03, 8'(cfg.divider_ratio_code));
        h.w(1'b0, 8'hC8);
        chk("comdir", 8'h01, 8'(cfg.com_scan_reverse));
        h.w(1'b0, 8'h7F);
        chk("line", 8'h3F, 8'(cfg.start_line));
        h.w(1'b0, 8'hA7);
        h.w(1'b0, 8'hA3);
        chk("inv_bias", 8'h03, 8'({cfg.reverse_video, cfg.bias_sel}));
        h.s(8'hA6);
        chk("ser_inv", 8'h00, 8'(cfg.reverse_video));
        h.w(1'b0, 8'h81);
        h.w(1'b0, 8'hE2);
        chk("contrast", 8'h22, 8'(cfg.contrast_code));
        chk("line", 8'h3F, 8'(cfg.start_line));
        h.w(1'b0, 8'hF8);
        h.w(1'b0, 8'h03);
        chk("pump", 8'h03, 8'({cfg.test_mode, cfg.pump_multiplier}));
        h.w(1'b0, 8'hAC);
        h.w(1'b0, 8'h00);
        chk("wake", 8'h00, 8'(cfg.wake_mode));
        h.w(1'b0, 8'h18);
        h.w(1'b0, 8'h03);
        h.w(1'b1, 8'h55);
        chk("col", 8'h83, addr.column);
        h.w(1'b0, 8'hB8);
        chk("page", 8'h08, 8'(addr.page));
        h.w(1'b0, 8'h10);
        h.w(1'b0, 8'h05);
        h.r(1'b1, v);
        chk("col", 8'h06, addr.column);
        h.w(1'b0, 8'hE0);
        h.r(1'b1, v);
        chk("col", 8'h06, addr.column);
        h.w(1'b1, 8'hAA);
        chk("col", 8'h07, addr.column);
        h.w(1'b0, 8'hEE);
        chk("col", 8'h06, addr.column);
        h.r(1'b1, v);
        chk("icon", 8'h00, v);
        h.w(1'b0, 8'hF0);
        chk("test", 8'h01, 8'(cfg.test_mode));
        h.w(1'b0, 8'hE3);
        chk("test", 8'h00, 8'(cfg.test_mode));
        h.w(1'b0, 8'hE2);
        chk("sw_rst", 8'h20, {cfg.start_line[1:0], cfg.contrast_code});
        chk("sw_keep", 8'h0F, 8'({cfg.com_scan_reverse, addr.column[0], cfg.display_on,
            cfg.bias_sel, cfg.pump_multiplier}));
        h.w(1'b0, 8'hAE);
        h.w(1'b0, 8'hA5);
        chk("psave", 8'h03, 8'({drive.power_save, drive.outputs_ground}));
        hw_init_n <= 1'b0;
        repeat (10) @(posedge clk);
        chk("hw_rst", 8'h00, 8'({cfg.display_on, cfg.bias_sel, cfg.pump_multiplier,
            cfg.boost_on, cfg.all_pixels_on, cfg.seg_scan_reverse}));
        chk("hw_busy", 8'h03, 8'({busy, rst_act}));
        hw_init_n <= 1'b1;
        h.r(1'b0, v);
        chk("status", 8'h00, v);
        report_and_stop();
    end
endmodule
